//--- pipc_map.svh
// Register offsets, field positions, command codes and timing counts of the poll/cascade host
`ifndef PIPC_MAP_SVH
`define PIPC_MAP_SVH

// Own register map, byte addresses on the AHB-Lite slave
`define PIPC_OFS_CMD 8'h00
`define PIPC_OFS_STATUS 8'h04
`define PIPC_OFS_RESULT 8'h08

// Command register fields
`define PIPC_CMD_DATA_LSB 0
`define PIPC_CMD_RSEL_BIT 8
`define PIPC_CMD_OP_LSB 9
`define PIPC_CMD_TGT_LSB 12
`define PIPC_CMD_MST_LSB 14
`define PIPC_CMD_RESET 16'h0000

// Status register fields
`define PIPC_STAT_BUSY_BIT 0
`define PIPC_STAT_INT_BIT 1
`define PIPC_STAT_PEND_BIT 2
`define PIPC_STAT_LVL_LSB 4

// Device command words issued by the controller
`define PIPC_WORD3_BASE 8'h08
`define PIPC_WORD3_POLL 8'h04
`define PIPC_WORD3_READ 8'h02
`define PIPC_WORD3_ISR 8'h01
`define PIPC_WORD2_NS_EOI 8'h20
`define PIPC_POLL_PEND_BIT 7

// Timing of the device pins, figures in ns and derived cycle counts
`define PIPC_CLK_NS 50
`define PIPC_SETUP_NS 10
`define PIPC_RD_PULSE_NS 160
`define PIPC_WR_PULSE_NS 190
`define PIPC_HOLD_NS 5
`define PIPC_GAP_NS 400
`define PIPC_SETUP_CYC ((`PIPC_SETUP_NS + `PIPC_CLK_NS - 1) / `PIPC_CLK_NS)
`define PIPC_RD_PULSE_CYC ((`PIPC_RD_PULSE_NS + `PIPC_CLK_NS - 1) / `PIPC_CLK_NS)
`define PIPC_WR_PULSE_CYC ((`PIPC_WR_PULSE_NS + `PIPC_CLK_NS - 1) / `PIPC_CLK_NS)
`define PIPC_HOLD_CYC ((`PIPC_HOLD_NS + `PIPC_CLK_NS - 1) / `PIPC_CLK_NS)
`define PIPC_GAP_CYC ((`PIPC_GAP_NS + `PIPC_CLK_NS - 1) / `PIPC_CLK_NS)

`endif

//--- pipc_pkg.sv
// Types shared by the poll/cascade host modules
package pipc_pkg;

  // Operations that software may start through the command register
  typedef enum logic [2:0] {
    PIPC_OP_NONE = 3'h0,
    PIPC_OP_WRITE = 3'h1,
    PIPC_OP_READ = 3'h2,
    PIPC_OP_POLL = 3'h3,
    PIPC_OP_SELECT = 3'h4,
    PIPC_OP_ACK2 = 3'h5,
    PIPC_OP_ACK3 = 3'h6,
    PIPC_OP_EXIT = 3'h7
  } pipc_op_t;

  // Kinds of single pin cycle
  typedef enum logic [1:0] {
    PIPC_CYC_WRITE = 2'h0,
    PIPC_CYC_READ = 2'h1,
    PIPC_CYC_ACK = 2'h2
  } pipc_cyc_t;

endpackage : pipc_pkg

//--- pipc_seq_if.sv
// Request and answer between the operation sequencer and the pin strobe engine
`timescale 1ns/1ns
`default_nettype none
interface pipc_seq_if;
  logic req;              // One-cycle start of a pin cycle
  pipc_pkg::pipc_cyc_t kind; // Write, read or acknowledge
  logic [1:0] cs_index;   // Which device chip select
  logic rsel;             // Register-select level
  logic [7:0] wdata;      // Byte for a write
  logic busy;             // Engine occupied
  logic done;             // One-cycle end of the pin cycle
  logic [7:0] rdata;      // Byte captured at the end of a read or acknowledge pulse

  modport ctrl (output req, kind, cs_index, rsel, wdata, input busy, done, rdata);
  modport eng (input req, kind, cs_index, rsel, wdata, output busy, done, rdata);
endinterface : pipc_seq_if
`default_nettype wire

//--- pipc_strobe_seq.sv
// Pin strobe engine: one write, read or acknowledge cycle on the device pins
`timescale 1ns/1ns
`default_nettype none
`include "pipc_map.svh"
module pipc_strobe_seq #(
  parameter int CS_COUNT = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request side
  pipc_seq_if.eng sq,
  // Device pins
  output logic [CS_COUNT-1:0] pic_cs_n,
  output logic pic_rd_n,
  output logic pic_wr_n,
  output logic pic_register_select,
  output logic pic_acknowledge_strobe_n,
  output logic [7:0] pic_data_out,
  output logic pic_data_oe,
  input wire logic [7:0] pic_data_in
);

  // One-hot phases of a pin cycle
  typedef enum logic [4:0] {
    PIPC_PH_IDLE = 5'h01,
    PIPC_PH_SETUP = 5'h02,
    PIPC_PH_PULSE = 5'h04,
    PIPC_PH_HOLD = 5'h08,
    PIPC_PH_RECOV = 5'h10
  } pipc_phase_t;

  pipc_phase_t phase; // Current phase
  logic [3:0] cnt;    // Cycles left in the phase
  pipc_pkg::pipc_cyc_t kind; // Latched kind of cycle

  assign sq.busy = (phase != PIPC_PH_IDLE);

  // Phase walk; the recovery covers the longest gap so any command may follow
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase <= PIPC_PH_IDLE;
      cnt <= 4'h0;
      kind <= pipc_pkg::PIPC_CYC_WRITE;
      sq.done <= 1'b0;
    end
    else
    begin
      sq.done <= 1'b0;
      case (phase)
        PIPC_PH_IDLE:
        begin
          if (sq.req)
          begin
            kind <= sq.kind;
            cnt <= 4'(`PIPC_SETUP_CYC - 1);
            phase <= PIPC_PH_SETUP;
          end
        end
        PIPC_PH_SETUP:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            // Writes take the write pulse count; at this clock both pulses round to 4 cycles
            cnt <= (kind == pipc_pkg::PIPC_CYC_WRITE) ? 4'(`PIPC_WR_PULSE_CYC - 1)
                                                      : 4'(`PIPC_RD_PULSE_CYC - 1);
            phase <= PIPC_PH_PULSE;
          end
        PIPC_PH_PULSE:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            cnt <= 4'(`PIPC_HOLD_CYC - 1);
            phase <= PIPC_PH_HOLD;
          end
        PIPC_PH_HOLD:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            cnt <= 4'(`PIPC_GAP_CYC - 1);
            phase <= PIPC_PH_RECOV;
          end
        PIPC_PH_RECOV:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            sq.done <= 1'b1;
            phase <= PIPC_PH_IDLE;
          end
        default:
          phase <= PIPC_PH_IDLE;
      endcase
    end
  end

  // Address, chip select and write data stand from setup through hold
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pic_cs_n <= '1;
      pic_register_select <= 1'b0;
      pic_data_out <= 8'h00;
      pic_data_oe <= 1'b0;
    end
    else if (phase == PIPC_PH_IDLE && sq.req)
    begin
      // Acknowledge cycles carry no chip select
      for (int i = 0; i < CS_COUNT; i++)
        pic_cs_n[i] <= !(sq.kind != pipc_pkg::PIPC_CYC_ACK && sq.cs_index == 2'(i));
      pic_register_select <= sq.rsel;
      pic_data_out <= sq.wdata;
      pic_data_oe <= (sq.kind == pipc_pkg::PIPC_CYC_WRITE);
    end
    else if (phase == PIPC_PH_HOLD && cnt == 4'h0)
    begin
      pic_cs_n <= '1;
      pic_data_oe <= 1'b0;
    end
  end

  // Strobes low for the pulse phase; read byte taken at its last edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pic_rd_n <= 1'b1;
      pic_wr_n <= 1'b1;
      pic_acknowledge_strobe_n <= 1'b1;
      sq.rdata <= 8'h00;
    end
    else if (phase == PIPC_PH_SETUP && cnt == 4'h0)
    begin
      pic_wr_n <= (kind != pipc_pkg::PIPC_CYC_WRITE);
      pic_rd_n <= (kind != pipc_pkg::PIPC_CYC_READ);
      pic_acknowledge_strobe_n <= (kind != pipc_pkg::PIPC_CYC_ACK);
    end
    else if (phase == PIPC_PH_PULSE && cnt == 4'h0)
    begin
      pic_rd_n <= 1'b1;
      pic_wr_n <= 1'b1;
      pic_acknowledge_strobe_n <= 1'b1;
      if (kind != pipc_pkg::PIPC_CYC_WRITE)
        sq.rdata <= pic_data_in;
    end
  end

endmodule : pipc_strobe_seq
`default_nettype wire

//--- pipc_host.sv
// Host controller that drives the priority interrupt controller through its pins
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pipc_map.svh"
// What this block does, and what it assumes of the requesters
// - Poll write, then next read acknowledges
// - Select status via third word, select bit
// - Requester drops level request before end-of-service
// - Requests stay high past first acknowledge
// - Exit: slave END_OF_SERVICE_COMMAND, read service, master conditionally
module pipc_host #(
  parameter int CS_COUNT = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Device parallel pins
  output logic [CS_COUNT-1:0] pic_cs_n,
  output logic pic_rd_n,
  output logic pic_wr_n,
  output logic pic_register_select,
  output logic pic_acknowledge_strobe_n,
  output logic [7:0] pic_data_out,
  output logic pic_data_oe,
  input wire logic [7:0] pic_data_in,
  // Device interrupt output
  input wire logic pic_int
);

  // One-hot operation states
  typedef enum logic [2:0] {
    PIPC_ST_IDLE = 3'h1,
    PIPC_ST_ISSUE = 3'h2,
    PIPC_ST_WAIT = 3'h4
  } pipc_state_t;

  pipc_seq_if sq ();           // Link to the pin strobe engine

  pipc_state_t state;          // Operation state
  logic [15:0] cmd;            // Last accepted command word
  logic [1:0] step;            // Pin cycle index inside the operation
  logic [23:0] result;         // Last read bytes, newest in the low byte
  logic int_seen;              // Device interrupt level, registered
  logic addr_valid;            // A transfer is in its data phase
  logic addr_write;            // That transfer writes
  logic [7:0] addr_ofs;        // Its byte offset
  pipc_pkg::pipc_op_t op;      // Operation field of the command
  logic [7:0] cmd_data;        // Data field of the command
  logic [1:0] cmd_tgt;         // Target chip select
  logic [1:0] cmd_mst;         // Master chip select, for exit only

  // Step decode outputs
  pipc_pkg::pipc_cyc_t step_kind;
  logic [1:0] step_cs;
  logic step_rsel;
  logic [7:0] step_data;
  logic step_last;             // This is the operation's final pin cycle
  logic [15:0] status_word;    // Status register image

  assign op = pipc_pkg::pipc_op_t'(cmd[`PIPC_CMD_OP_LSB +: 3]);
  assign cmd_data = cmd[`PIPC_CMD_DATA_LSB +: 8];
  assign cmd_tgt = cmd[`PIPC_CMD_TGT_LSB +: 2];
  assign cmd_mst = cmd[`PIPC_CMD_MST_LSB +: 2];

  // Pin engine; it owns every device pin so those outputs come from its flops
  pipc_strobe_seq #(
    .CS_COUNT(CS_COUNT)
  ) u_strobe (
    .hclk(hclk),
    .hresetn(hresetn),
    .sq(sq.eng),
    .pic_cs_n(pic_cs_n),
    .pic_rd_n(pic_rd_n),
    .pic_wr_n(pic_wr_n),
    .pic_register_select(pic_register_select),
    .pic_acknowledge_strobe_n(pic_acknowledge_strobe_n),
    .pic_data_out(pic_data_out),
    .pic_data_oe(pic_data_oe),
    .pic_data_in(pic_data_in)
  );

  // Turn operation and step into one pin cycle
  always_comb
  begin
    step_kind = pipc_pkg::PIPC_CYC_WRITE;
    step_cs = cmd_tgt;
    step_rsel = cmd[`PIPC_CMD_RSEL_BIT];
    step_data = cmd_data;
    step_last = 1'b1;
    case (op)
      pipc_pkg::PIPC_OP_WRITE:
        step_kind = pipc_pkg::PIPC_CYC_WRITE;
      pipc_pkg::PIPC_OP_READ:
        // Select high gives the mask, low the chosen status register
        step_kind = pipc_pkg::PIPC_CYC_READ;
      pipc_pkg::PIPC_OP_POLL:
      begin
        // Poll word first; the very next read is the poll answer
        step_rsel = 1'b0;
        step_data = `PIPC_WORD3_BASE | `PIPC_WORD3_POLL;
        step_kind = (step == 2'h0) ? pipc_pkg::PIPC_CYC_WRITE
                                   : pipc_pkg::PIPC_CYC_READ;
        step_last = (step != 2'h0);
      end
      pipc_pkg::PIPC_OP_SELECT:
      begin
        // Data bit 0 picks in-service (1) or request (0) flags
        step_rsel = 1'b0;
        step_data = `PIPC_WORD3_BASE | `PIPC_WORD3_READ
                    | (cmd_data[0] ? `PIPC_WORD3_ISR : 8'h00);
      end
      pipc_pkg::PIPC_OP_ACK2:
      begin
        // Two-pulse acknowledge of the 16-bit bus mode
        step_kind = pipc_pkg::PIPC_CYC_ACK;
        step_last = (step == 2'h1);
      end
      pipc_pkg::PIPC_OP_ACK3:
      begin
        // Three pulses; cascade code stands from first to third
        step_kind = pipc_pkg::PIPC_CYC_ACK;
        step_last = (step == 2'h2);
      end
      pipc_pkg::PIPC_OP_EXIT:
      begin
        step_last = 1'b0;
        step_rsel = 1'b0;
        case (step)
          2'h0:
            step_data = `PIPC_WORD2_NS_EOI;
          2'h1:
            step_data = `PIPC_WORD3_BASE | `PIPC_WORD3_READ | `PIPC_WORD3_ISR;
          2'h2:
          begin
            // Slave in-service read decides whether the master gets one
            step_kind = pipc_pkg::PIPC_CYC_READ;
            step_last = 1'b0;
          end
          default:
          begin
            step_cs = cmd_mst;
            step_data = `PIPC_WORD2_NS_EOI;
            step_last = 1'b1;
          end
        endcase
      end
      default:
        step_last = 1'b1;
    endcase
  end

  // Operation walk: issue each pin cycle, wait for it, then the next
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= PIPC_ST_IDLE;
      step <= 2'h0;
      sq.req <= 1'b0;
    end
    else
    begin
      sq.req <= 1'b0;
      case (state)
        PIPC_ST_IDLE:
          // A new command lands here from the bus write below
          if (addr_valid && addr_write && addr_ofs == `PIPC_OFS_CMD
              && hwdata[`PIPC_CMD_OP_LSB +: 3] != 3'h0)
          begin
            step <= 2'h0;
            state <= PIPC_ST_ISSUE;
          end
        PIPC_ST_ISSUE:
        begin
          sq.req <= 1'b1;
          state <= PIPC_ST_WAIT;
        end
        PIPC_ST_WAIT:
          if (sq.done)
          begin
            // Exit ends early when the slave still has service flags set
            if (step_last || (op == pipc_pkg::PIPC_OP_EXIT && step == 2'h2
                              && sq.rdata != 8'h00))
              state <= PIPC_ST_IDLE;
            else
            begin
              step <= step + 2'h1;
              state <= PIPC_ST_ISSUE;
            end
          end
        default:
          state <= PIPC_ST_IDLE;
      endcase
    end
  end

  // Pin cycle fields for the engine, stable while it runs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sq.kind <= pipc_pkg::PIPC_CYC_WRITE;
      sq.cs_index <= 2'h0;
      sq.rsel <= 1'b0;
      sq.wdata <= 8'h00;
    end
    else if (state == PIPC_ST_ISSUE)
    begin
      sq.kind <= step_kind;
      sq.cs_index <= step_cs;
      sq.rsel <= step_rsel;
      sq.wdata <= step_data;
    end
  end

  // Every byte read back shifts into the result register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      result <= 24'h000000;
    else if (state == PIPC_ST_WAIT && sq.done && sq.kind != pipc_pkg::PIPC_CYC_WRITE)
      result <= {result[15:0], sq.rdata};
  end

  // Device interrupt output, taken as synchronous
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_seen <= 1'b0;
    else
      int_seen <= pic_int;
  end

  // Command register; a write while busy is ignored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd <= `PIPC_CMD_RESET;
    else if (state == PIPC_ST_IDLE && addr_valid && addr_write && addr_ofs == `PIPC_OFS_CMD)
      cmd <= hwdata[15:0];
  end

  // Address phase capture; the slave never stalls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_valid <= 1'b0;
      addr_write <= 1'b0;
      addr_ofs <= 8'h00;
    end
    else if (hready)
    begin
      addr_valid <= hsel && htrans[1];
      addr_write <= hwrite;
      addr_ofs <= haddr[7:0];
    end
  end

  // Status image: busy, interrupt, newest result byte split into the poll answer fields
  always_comb
  begin
    status_word = 16'h0000;
    status_word[`PIPC_STAT_BUSY_BIT] = (state != PIPC_ST_IDLE);
    status_word[`PIPC_STAT_INT_BIT] = int_seen;
    status_word[`PIPC_STAT_PEND_BIT] = result[`PIPC_POLL_PEND_BIT];
    status_word[`PIPC_STAT_LVL_LSB +: 3] = result[2:0];
  end

  // Read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
      case (haddr[7:0])
        `PIPC_OFS_CMD:
          hrdata <= {16'h0000, cmd};
        `PIPC_OFS_STATUS:
          hrdata <= {16'h0000, status_word};
        `PIPC_OFS_RESULT:
          hrdata <= {8'h00, result};
        default:
          hrdata <= 32'h00000000; // Unmapped reads as zero
      endcase
  end

  // Zero-wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule : pipc_host
`default_nettype wire

//--- pipc_host_props.sv
// Concurrent checks on the bus answer and device pins of the poll/cascade host
`timescale 1ns/1ns
`default_nettype none
module pipc_host_props #(
  parameter int CS_COUNT = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Device pins
  input wire logic [CS_COUNT-1:0] pic_cs_n,
  input wire logic pic_rd_n,
  input wire logic pic_wr_n,
  input wire logic pic_acknowledge_strobe_n,
  input wire logic pic_data_oe
);
  // One domain, so one clock and one reset for all checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // All three strobes inactive
  logic idle;
  assign idle = pic_rd_n && pic_wr_n && pic_acknowledge_strobe_n;

  a_ready_always: assert property (hreadyout) else $error("hreadyout seen low");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_single_select: assert property ($onehot0(~pic_cs_n)) else $error("two selects low");
  a_ack_unselected: assert property (!pic_acknowledge_strobe_n |-> &pic_cs_n)
    else $error("select low during acknowledge");
  a_rd_width: assert property ($fell(pic_rd_n) |-> !pic_rd_n [*4] ##1 pic_rd_n)
    else $error("read pulse width wrong");
  a_wr_width: assert property ($fell(pic_wr_n) |-> !pic_wr_n [*4] ##1 pic_wr_n)
    else $error("write pulse width wrong");
  a_rd_selected: assert property ($fell(pic_rd_n) |-> !(&$past(pic_cs_n)))
    else $error("read without select setup");
  a_wr_hold: assert property ($rose(pic_wr_n) |-> pic_data_oe && !(&pic_cs_n) ##1 &pic_cs_n)
    else $error("write hold wrong");
  a_oe_write: assert property (!pic_wr_n |-> pic_data_oe)
    else $error("write without data drive");
  a_oe_read: assert property (!(pic_rd_n && pic_acknowledge_strobe_n) |-> !pic_data_oe)
    else $error("host drives during read");
  a_strobe_gap: assert property ($rose(idle) |-> ##1 idle [*8])
    else $error("recovery too short");
endmodule : pipc_host_props
`default_nettype wire

//--- pipc_dev_model.sv
// Behavioural model of the interrupt controller seen through its parallel pins
`timescale 1ns/1ns
`default_nettype none
module pipc_dev_model #(
  parameter logic [7:0] VEC_BASE = 8'h40, // Vector base, arbitrary
  parameter logic [7:0] ACK_FIRST = 8'hCD // First acknowledge byte, arbitrary
) (
  // Host strobes
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic register_select,
  input wire logic acknowledge_strobe_n,
  // Data bus halves
  input wire logic [7:0] din,
  output logic [7:0] dout,
  // Requests and interrupt
  input wire logic [7:0] request_input,
  output logic int_out
);
  logic [7:0] pending_request_flags = 8'h00; // Unmasked request latch
  logic [7:0] active_service_flags = 8'h00; // Levels in service
  logic [7:0] channel_inhibit = 8'h00; // Mask
  logic [7:0] req_q = 8'h00; // Previous request levels
  logic [7:0] frozen = 8'h00; // Snapshot taken by a poll command
  logic [7:0] bus_val = 8'h00; // Byte last put on the bus
  logic [3:0] won = 4'h7; // Found flag and level of the last resolve
  logic poll_armed = 1'b0; // Next read is a poll acknowledge
  logic isr_chosen = 1'b0;
  logic driving = 1'b0; // Model drives the bus
  int ack_idx = 0; // Pulse index in an acknowledge sequence

  // Lowest set index wins; nothing found gives the default level 7
  task automatic take(input logic [7:0] cand);
    won = 4'h7;
    for (int i = 7; i >= 0; i--)
    begin
      if (cand[i])
        won = {1'b1, i[2:0]};
    end
    if (won[3])
    begin
      active_service_flags[won[2:0]] = 1'b1;
      pending_request_flags[won[2:0]] = 1'b0;
    end
  endtask : take

  // Edge mode: a rise latches, a fall before service withdraws the request
  always @(request_input)
  begin
    pending_request_flags = (pending_request_flags | (request_input & ~req_q)) & request_input;
    req_q = request_input;
  end

  // Any select starts a fresh acknowledge count
  always @(negedge cs_n) ack_idx = 0;

  // Writes land at the trailing edge of the write strobe
  always @(posedge wr_n)
  begin
    if (!cs_n && register_select)
      channel_inhibit = din;
    else if (!cs_n && din[4:3] == 2'b01)
    begin
      if (din[2])
      begin
        poll_armed = 1'b1;
        frozen = pending_request_flags & ~channel_inhibit;
      end
      else if (din[1])
        isr_chosen = din[0];
    end
    else if (!cs_n && din[5] && din[4:3] == 2'b00)
      active_service_flags = active_service_flags & (active_service_flags - 8'h01);
  end

  // Reads: poll byte, mask, or the chosen status register
  always @(negedge rd_n)
  begin
    if (!cs_n)
    begin
      if (poll_armed)
      begin
        take(frozen);
        bus_val = {won[3], 4'h0, won[2:0]};
        poll_armed = 1'b0;
      end
      else if (register_select)
        bus_val = channel_inhibit;
      else
        bus_val = isr_chosen ? active_service_flags : pending_request_flags;
      driving = 1'b1;
    end
  end

  // First pulse resolves, later pulses carry the vector
  always @(negedge acknowledge_strobe_n)
  begin
    if (ack_idx == 0)
      take(pending_request_flags & ~channel_inhibit);
    bus_val = (ack_idx == 0) ? ACK_FIRST : (VEC_BASE | {5'h00, won[2:0]});
    ack_idx++;
    driving = 1'b1;
  end

  // Released bus shows the inverse, so a stale byte cannot pass
  always @(posedge rd_n or posedge acknowledge_strobe_n) driving = 1'b0;
  assign dout = driving ? bus_val : ~bus_val;
  assign int_out = |(pending_request_flags & ~channel_inhibit);
endmodule : pipc_dev_model
`default_nettype wire

//--- pipc_host_tb.sv
// Self-checking bench for the poll/cascade host driving a device model
`timescale 1ns/1ns
`default_nettype none
module pipc_host_tb;
  // Clock, reset and AHB-Lite master signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  // Device pins
  wire logic [3:0] pic_cs_n;
  wire logic pic_rd_n;
  wire logic pic_wr_n;
  wire logic pic_rs;
  wire logic pic_ack_n;
  wire logic [7:0] pic_dout;
  wire logic pic_oe;
  wire logic [7:0] pic_din;
  wire logic pic_int;
  logic [7:0] req = 8'h00; // Request levels into the model
  int errors = 0;
  int num_checks = 0;
  int mst_wr = 0; // Writes seen on the master select
  logic [31:0] rd; // Last bus read data

  always #25 hclk = ~hclk;

  pipc_host #(.CS_COUNT(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pic_cs_n(pic_cs_n),
    .pic_rd_n(pic_rd_n), .pic_wr_n(pic_wr_n), .pic_register_select(pic_rs),
    .pic_acknowledge_strobe_n(pic_ack_n), .pic_data_out(pic_dout), .pic_data_oe(pic_oe),
    .pic_data_in(pic_din), .pic_int(pic_int));

  pipc_dev_model DEV (.cs_n(pic_cs_n[0]), .rd_n(pic_rd_n), .wr_n(pic_wr_n),
    .register_select(pic_rs), .acknowledge_strobe_n(pic_ack_n), .din(pic_dout),
    .dout(pic_din), .request_input(req), .int_out(pic_int));

  // Master end-of-service writes go to select 1
  always @(negedge pic_wr_n) if (pic_cs_n[1] === 1'b0) mst_wr++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single word transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Start an operation and wait for busy to clear, bounded
  task automatic op(input pipc_pkg::pipc_op_t code, input logic [7:0] d, input logic rs);
    int n;
    ahb(1'b1, 32'h0000_0000, {16'h0000, 2'h1, 2'h0, code, rs, d});
    repeat (3) @(posedge hclk);
    n = 0;
    do
    begin
      ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    check({31'h0, rd[0]}, 32'h0000_0000);
  endtask : op

  // Newest byte of the result register
  task automatic byte_is(input logic [7:0] exp);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check({24'h0, rd[7:0]}, {24'h0, exp});
  endtask : byte_is

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Cuts a hang short well past the expected run length
  initial
  begin
    #2000000;
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped write and read
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    end_test("reset");
    // Mask write and direct mask read
    op(pipc_pkg::PIPC_OP_WRITE, 8'hA5, 1'b1);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b1);
    byte_is(8'hA5);
    req <= 8'h0C;
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h0C);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd, 32'h0000_0042);
    end_test("status");
    // Poll skips masked level 2, reports level 3
    op(pipc_pkg::PIPC_OP_POLL, 8'h00, 1'b0);
    byte_is(8'h83);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd, 32'h0000_0034);
    op(pipc_pkg::PIPC_OP_SELECT, 8'h01, 1'b0);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h08);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h08);
    op(pipc_pkg::PIPC_OP_SELECT, 8'h00, 1'b0);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h04);
    end_test("poll");
    // Poll together with read-register: the poll wins
    op(pipc_pkg::PIPC_OP_WRITE, 8'h00, 1'b1);
    op(pipc_pkg::PIPC_OP_WRITE, 8'h0F, 1'b0);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h82);
    end_test("poll_wins");
    // Exit: the master is told only once the slave is empty
    op(pipc_pkg::PIPC_OP_EXIT, 8'h00, 1'b0);
    byte_is(8'h08);
    check(mst_wr, 32'h0000_0000);
    op(pipc_pkg::PIPC_OP_EXIT, 8'h00, 1'b0);
    byte_is(8'h00);
    check(mst_wr, 32'h0000_0001);
    end_test("exit");
    // Fresh rise, then three and two pulse acknowledges
    req <= 8'h00;
    @(posedge hclk);
    req <= 8'h20;
    op(pipc_pkg::PIPC_OP_SELECT, 8'h00, 1'b0);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h20);
    op(pipc_pkg::PIPC_OP_ACK3, 8'h00, 1'b0);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, 32'h00CD_4545);
    req <= 8'h60;
    @(posedge hclk);
    req <= 8'h20;
    op(pipc_pkg::PIPC_OP_SELECT, 8'h01, 1'b0);
    op(pipc_pkg::PIPC_OP_ACK2, 8'h00, 1'b0);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, 32'h0045_CD47);
    op(pipc_pkg::PIPC_OP_READ, 8'h00, 1'b0);
    byte_is(8'h20);
    op(pipc_pkg::PIPC_OP_NONE, 8'h00, 1'b0);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check({31'h0, rd[0]}, 32'h0000_0000);
    end_test("acknowledge");
    stop_test();
  end
endmodule : pipc_host_tb

bind pipc_host pipc_host_props #(.CS_COUNT(CS_COUNT)) u_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .pic_cs_n(pic_cs_n), .pic_rd_n(pic_rd_n),
  .pic_wr_n(pic_wr_n), .pic_acknowledge_strobe_n(pic_acknowledge_strobe_n),
  .pic_data_oe(pic_data_oe));
`default_nettype wire
